// [src/irpc_pkg.sv]
// shared constants and types for the interrupt request and priority control block
package irpc_pkg;

  localparam int unsigned AXI_ADDR_W = 8;
  localparam int unsigned AXI_DATA_W = 32;

  // register byte addresses
  localparam logic [AXI_ADDR_W-1:0] OFS_LONGWORD = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] OFS_REQUESTS = 8'h08;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // processor status longword fields
  localparam int unsigned LEVEL_LSB = 0;
  localparam int unsigned LEVEL_W = 5;
  localparam int unsigned TRACE_ENABLE_BIT = 5;
  localparam int unsigned TRACE_PENDING_BIT = 6;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 5'h00;

  // status register fields
  localparam int unsigned STAT_ID_LSB = 0;
  localparam int unsigned STAT_FLAG_BIT = 4;
  localparam int unsigned STAT_CODE_LSB = 5;
  localparam int unsigned STAT_DMASK_BIT = 8;
  localparam int unsigned STAT_STALL_BIT = 9;

  localparam int unsigned ID_W = 4;
  localparam int unsigned CODE_W = 3;
  localparam int unsigned ID_HALT_BIT = 3;

  // encoder input positions and codes
  localparam logic [CODE_W-1:0] CODE_NONE = 3'h0;
  localparam logic [CODE_W-1:0] CODE_LINE4 = 3'h1;
  localparam logic [CODE_W-1:0] CODE_ATTENTION = 3'h2;
  localparam logic [CODE_W-1:0] CODE_LINE5 = 3'h3;
  localparam logic [CODE_W-1:0] CODE_LINE6 = 3'h4;
  localparam logic [CODE_W-1:0] CODE_LINE7 = 3'h5;
  localparam logic [CODE_W-1:0] CODE_TIMER = 3'h6;
  localparam logic [CODE_W-1:0] CODE_PWR = 3'h7;

  // assigned priority levels
  localparam logic [LEVEL_W-1:0] LVL_NONE = 5'h00;
  localparam logic [LEVEL_W-1:0] LVL_PWR = 5'h1e;
  localparam logic [LEVEL_W-1:0] LVL_TIMER = 5'h18;
  localparam logic [LEVEL_W-1:0] LVL_LINE7 = 5'h17;
  localparam logic [LEVEL_W-1:0] LVL_LINE6 = 5'h16;
  localparam logic [LEVEL_W-1:0] LVL_LINE5 = 5'h15;
  localparam logic [LEVEL_W-1:0] LVL_ATTENTION = 5'h14;
  localparam logic [LEVEL_W-1:0] LVL_LINE4 = 5'h14;

  // function-2 field of the miscellaneous microinstruction
  localparam int unsigned FUNC2_W = 3;
  localparam logic [FUNC2_W-1:0] FUNC2_MASK_DISPATCH = 3'h1;
  localparam logic [FUNC2_W-1:0] FUNC2_MASK_HALT_TRACE = 3'h6;

  typedef struct packed {
    logic power_fail;
    logic interval_timer;
    logic bus_request_line7;
    logic bus_request_line6;
    logic bus_request_line5;
    logic console_attention_request;
    logic bus_request_line4;
    logic console_stop_request;
    logic fast_port;
  } irpc_req_type;

  localparam int unsigned REQ_W = $bits(irpc_req_type);

  typedef struct packed {
    logic misc_valid;
    logic [FUNC2_W-1:0] func2;
  } irpc_micro_type;

endpackage : irpc_pkg

// [src/irpc_top.sv]
// interrupt request register, priority encoder, identifier and flag control with AXI4-Lite view
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module irpc_top
  import irpc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // asynchronous request pins
  input wire irpc_req_type req_pins,
  // microsequencer side
  input wire irpc_micro_type micro,
  input wire logic stat_read_enable,
  input wire logic vector_collect,
  input wire logic vector_received,
  output logic processor_interrupt_flag,
  output logic dispatch_mask_flop,
  output logic fast_port_skip,
  output logic [ID_W-1:0] read_bus,
  output logic cpu_clock_stall,
  // AXI4-Lite slave
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [AXI_DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // highest asserted input wins; input 7 outranks all
  function automatic logic [CODE_W-1:0] encode(input logic [7:1] lines);
    logic [CODE_W-1:0] code;
    code = CODE_NONE;
    for (int i = 1; i <= 7; i++) begin
      if (lines[i]) begin
        code = CODE_W'(i);
      end
    end
    return code;
  endfunction : encode

  function automatic logic [LEVEL_W-1:0] level_of(input logic [CODE_W-1:0] code);
    logic [LEVEL_W-1:0] lvl;
    case (code)
      CODE_PWR: lvl = LVL_PWR;
      CODE_TIMER: lvl = LVL_TIMER;
      CODE_LINE7: lvl = LVL_LINE7;
      CODE_LINE6: lvl = LVL_LINE6;
      CODE_LINE5: lvl = LVL_LINE5;
      CODE_ATTENTION: lvl = LVL_ATTENTION;
      CODE_LINE4: lvl = LVL_LINE4;
      default: lvl = LVL_NONE;
    endcase
    return lvl;
  endfunction : level_of

  irpc_req_type req_meta;
  irpc_req_type req_sync;
  logic [LEVEL_W-1:0] interrupt_priority_level;
  logic trace_enable;
  logic trace_pending_bit;
  logic [ID_W-1:0] id_flops;
  logic [CODE_W-1:0] enc_code;
  logic [7:1] enc_lines;
  logic level_wins;
  logic halt_trace_mask;
  logic trace_req;
  logic next_flag;

  // request register: pins pass two flops; a request is held only while its source drives it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_meta <= '0;
      req_sync <= '0;
    end else begin
      req_meta <= req_pins;
      req_sync <= req_meta;
    end
  end

  always_comb begin
    enc_lines = {req_sync.power_fail, req_sync.interval_timer, req_sync.bus_request_line7,
                 req_sync.bus_request_line6, req_sync.bus_request_line5,
                 req_sync.console_attention_request, req_sync.bus_request_line4};
    enc_code = encode(enc_lines);
    // no assigned level reaches 1f, so that processor level shuts every level request out
    level_wins = (enc_code != CODE_NONE) && (level_of(enc_code) > interrupt_priority_level);
    halt_trace_mask = micro.misc_valid && (micro.func2 == FUNC2_MASK_HALT_TRACE);
    trace_req = (trace_enable || trace_pending_bit) && !halt_trace_mask;
    // a held halt identifier must not raise the flag while the mask is applied
    next_flag = req_sync.fast_port || trace_req || (id_flops[CODE_W-1:0] != '0)
                || (id_flops[ID_HALT_BIT] && !halt_trace_mask);
  end

  // identifier flops: reloaded every microcycle so they drop once the cause is serviced
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      id_flops <= '0;
    end else begin
      id_flops[CODE_W-1:0] <= level_wins ? enc_code : CODE_NONE;
      id_flops[ID_HALT_BIT] <= req_sync.console_stop_request && !halt_trace_mask;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      processor_interrupt_flag <= 1'b0;
    end else begin
      processor_interrupt_flag <= next_flag;
    end
  end

  // dispatch mask lives one microcycle; the sequencer reissues it before each masked decode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dispatch_mask_flop <= 1'b0;
    end else begin
      dispatch_mask_flop <= micro.misc_valid && (micro.func2 == FUNC2_MASK_DISPATCH);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_port_skip <= 1'b0;
    end else begin
      fast_port_skip <= req_sync.fast_port;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_bus <= '0;
    end else begin
      read_bus <= stat_read_enable ? ~id_flops : '0;
    end
  end

  // stall holds until the memory controller has the vector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_clock_stall <= 1'b0;
    end else begin
      cpu_clock_stall <= vector_collect && !vector_received;
    end
  end

  // AXI4-Lite write path: address and data accepted in either order, then one response
  logic [AXI_ADDR_W-1:0] wr_addr;
  logic [AXI_DATA_W-1:0] wr_data;
  logic [AXI_DATA_W/8-1:0] wr_strb;
  logic aw_held;
  logic w_held;
  logic wr_fire;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      wr_addr <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_addr == OFS_LONGWORD) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // software-owned processor level and trace bits; only byte lane 0 carries fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_priority_level <= LEVEL_RESET;
      trace_enable <= 1'b0;
      trace_pending_bit <= 1'b0;
    end else if (wr_fire && (wr_addr == OFS_LONGWORD) && wr_strb[0]) begin
      interrupt_priority_level <= wr_data[LEVEL_LSB +: LEVEL_W];
      trace_enable <= wr_data[TRACE_ENABLE_BIT];
      trace_pending_bit <= wr_data[TRACE_PENDING_BIT];
    end
  end

  // AXI4-Lite read path: one read at a time, answered the cycle after the address is taken
  logic [AXI_DATA_W-1:0] rd_word;
  logic rd_hit;

  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFS_LONGWORD: begin
        rd_word[LEVEL_LSB +: LEVEL_W] = interrupt_priority_level;
        rd_word[TRACE_ENABLE_BIT] = trace_enable;
        rd_word[TRACE_PENDING_BIT] = trace_pending_bit;
      end
      OFS_STATUS: begin
        rd_word[STAT_ID_LSB +: ID_W] = id_flops;
        rd_word[STAT_FLAG_BIT] = processor_interrupt_flag;
        rd_word[STAT_CODE_LSB +: CODE_W] = enc_code;
        rd_word[STAT_DMASK_BIT] = dispatch_mask_flop;
        rd_word[STAT_STALL_BIT] = cpu_clock_stall;
      end
      OFS_REQUESTS: begin
        rd_word[REQ_W-1:0] = req_sync;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : irpc_top

// [dv/irpc_top_properties.sv]
// concurrent checks on the ports of the interrupt request and priority control block
`timescale 1ns/10ps
module irpc_top_properties
  import irpc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire irpc_req_type req_pins,
  input wire irpc_micro_type micro,
  input wire logic stat_read_enable,
  input wire logic vector_collect,
  input wire logic vector_received,
  input wire logic processor_interrupt_flag,
  input wire logic dispatch_mask_flop,
  input wire logic fast_port_skip,
  input wire logic [ID_W-1:0] read_bus,
  input wire logic cpu_clock_stall
);
  logic mask1;
  logic mask6;
  assign mask1 = micro.misc_valid && micro.func2 == FUNC2_MASK_DISPATCH;
  assign mask6 = micro.misc_valid && micro.func2 == FUNC2_MASK_HALT_TRACE;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  mask_pulse_a: assert property (mask1 |=> dispatch_mask_flop)
    else $error("dispatch mask missing");
  mask_single_a: assert property (dispatch_mask_flop |-> $past(mask1))
    else $error("dispatch mask held too long");
  stall_a: assert property (cpu_clock_stall == $past(vector_collect && !vector_received))
    else $error("stall wrong");
  read_idle_a: assert property (!$past(stat_read_enable) |-> read_bus == '0)
    else $error("read bus driven while not enabled");
  fast_flag_a: assert property (fast_port_skip |-> processor_interrupt_flag)
    else $error("fast port without flag");
  // the halt mask may hide the stop request for the two edges it touches
  stop_flag_a: assert property (req_pins.console_stop_request [*5] |->
    processor_interrupt_flag || $past(mask6) || $past(mask6, 2))
    else $error("stop without flag");
  mask_clear_a: assert property ((req_pins == '0) [*5] ##0 mask6 |=> !processor_interrupt_flag)
    else $error("flag set under halt mask");
  reset_clear_a: assert property (disable iff (1'h0) !aresetn |=>
    !processor_interrupt_flag && !dispatch_mask_flop && read_bus == '0)
    else $error("reset left state set");
endmodule : irpc_top_properties
bind irpc_top irpc_top_properties irpc_top_properties_inst (.*);

// [dv/irpc_far_model.sv]
// far side: devices that drop a request when granted, and a late vector source
`timescale 1ns/10ps
module irpc_far_model
  import irpc_pkg::*;
#(
  parameter int unsigned DELAY = 4
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire irpc_req_type raise,
  input wire irpc_req_type grant,
  output irpc_req_type req_pins,
  output logic vector_received
);
  logic [3:0] cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_pins <= '0;
    end else begin
      req_pins <= (req_pins | raise) & ~grant;
    end
  end
  // slow on purpose so the collect has to wait
  always_ff @(posedge aclk) begin
    if (!aresetn || grant == '0) begin
      cnt <= 4'h0;
      vector_received <= 1'h0;
    end else if (cnt == 4'(DELAY)) begin
      vector_received <= 1'h1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : irpc_far_model

// [dv/tb.sv]
// self-checking bench for the interrupt request and priority control block
`timescale 1ns/10ps
module tb;
  import irpc_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  irpc_req_type req_pins;
  irpc_req_type raise = '0;
  irpc_req_type grant = '0;
  irpc_micro_type micro = '0;
  logic stat_read_enable = 0;
  logic vector_collect = 0;
  logic vector_received, processor_interrupt_flag, dispatch_mask_flop, fast_port_skip, cpu_clock_stall;
  logic [3:0] read_bus;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  int miscompares = 0;
  int checks = 0;
  int n;
  always #2.5 aclk = ~aclk;
  irpc_top irpc_top_inst (.*);
  irpc_far_model irpc_far_model_inst (.aclk, .aresetn, .raise, .grant, .req_pins, .vector_received);
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic tmo;
    if (n >= 50) begin
      miscompares++;
      summarize();
    end
  endtask : tmo
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 0;
    tmo();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    tmo();
  endtask : rd
  // read_bus shows the inverted identifier only in the cycle after the enable
  task automatic idr;
    @(posedge aclk);
    stat_read_enable <= 1;
    @(posedge aclk);
    stat_read_enable <= 0;
    #1;
  endtask : idr
  // request path is sync, identifier, flag: six edges covers it
  task automatic req(input irpc_req_type s, input irpc_req_type g);
    @(posedge aclk);
    raise <= s;
    grant <= g;
    @(posedge aclk);
    raise <= '0;
    grant <= '0;
    repeat (6) @(posedge aclk);
    #1;
  endtask : req
  task automatic msk(input logic [2:0] f);
    @(posedge aclk);
    micro <= {1'h1, f};
    @(posedge aclk);
    micro <= '0;
    #1;
  endtask : msk
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    rd(OFS_LONGWORD);
    chk("longword reset", 0, d);
    rd(OFS_STATUS);
    chk("idle code", 0, d[7:5]);
    rd(8'h0c);
    chk("unmapped", RESP_SLVERR, r);
    wr(OFS_STATUS, 0);
    chk("ro write", RESP_SLVERR, r);
    for (int i = 2; i < 9; i++) begin
      req(9'(1 << i), '0);
      idr();
      chk("id", {1'h1, ~3'(i - 1)}, read_bus);
      rd(OFS_STATUS);
      chk("code", i - 1, d[7:5]);
      chk("flag", 1, processor_interrupt_flag);
    end
    wr(OFS_LONGWORD, 32'h1e);
    idr();
    chk("level 1e", 4'hf, read_bus);
    chk("flag 1e", 0, processor_interrupt_flag);
    wr(OFS_LONGWORD, 32'h1d);
    idr();
    chk("level 1d", 4'h8, read_bus);
    req('0, 9'h100);
    idr();
    chk("timer low", 4'hf, read_bus);
    wr(OFS_LONGWORD, 32'h17);
    idr();
    chk("timer", 4'h9, read_bus);
    wr(OFS_LONGWORD, 32'h1f);
    req(9'h002, '0);
    idr();
    chk("stop", 4'h7, read_bus);
    chk("stop flag", 1, processor_interrupt_flag);
    msk(FUNC2_MASK_HALT_TRACE);
    chk("halt masked", 0, processor_interrupt_flag);
    req('0, 9'h1fe);
    rd(OFS_REQUESTS);
    chk("requests", 0, d);
    chk("flag clear", 0, processor_interrupt_flag);
    wr(OFS_LONGWORD, 32'h3f);
    idr();
    chk("trace flag", 1, processor_interrupt_flag);
    chk("trace id", 4'hf, read_bus);
    rd(OFS_LONGWORD);
    chk("longword", 32'h3f, d);
    // lane 0 unstrobed: the longword must keep its fields
    s_axi_wstrb <= 4'he;
    wr(OFS_LONGWORD, 0);
    s_axi_wstrb <= 4'hf;
    rd(OFS_LONGWORD);
    chk("unstrobed", 32'h3f, d);
    msk(FUNC2_MASK_HALT_TRACE);
    chk("trace masked", 0, processor_interrupt_flag);
    wr(OFS_LONGWORD, 0);
    req(9'h001, '0);
    chk("skip", 1, fast_port_skip);
    idr();
    chk("fast flag", 1, processor_interrupt_flag);
    chk("fast id", 4'hf, read_bus);
    req('0, 9'h001);
    for (int f = 0; f < 8; f++) begin
      msk(3'(f));
      chk("dmask", f == 1, dispatch_mask_flop);
    end
    req(9'h040, '0);
    @(posedge aclk);
    grant <= 9'h040;
    vector_collect <= 1;
    repeat (3) @(posedge aclk);
    #1 chk("stall", 1, cpu_clock_stall);
    n = 0;
    while (!vector_received && n < 50) begin
      @(posedge aclk);
      n++;
    end
    tmo();
    #1 chk("stall end", 0, cpu_clock_stall);
    @(posedge aclk);
    grant <= '0;
    vector_collect <= 0;
    repeat (6) @(posedge aclk);
    #1 chk("served", 0, processor_interrupt_flag);
    summarize();
  end
endmodule : tb
